// ===== rtl/cmi_consts.svh
// constants for the streaming cholesky matrix inverter
// ----------------------------------------------------------------------
// Overview of operation
// RULE1: factor, invert triangle, then multiply conjugate transpose
// RULE2: factor stage hands diagonal reciprocals to inversion
// RULE3: pipelined stages, dot engine width set by size; here one shared engine runs the three phases in turn, one matrix at a time
// RULE4: elements are 64-bit complex single precision
// RULE5: source gives 8-bit channel with each element
// RULE6: source sends n(n+1)/2 elements per matrix
// RULE7: lower triangle only, column-major, both directions
// RULE8: source idles latency minus element count between matrices
// RULE9: output valid for n(n+1)/2 consecutive cycles
// RULE10: output carries 8-bit channel with each element
// RULE11: output bus carries lower triangle of inverse
// RULE12: at least 16 channels, channelizer defaults 16
// RULE13: next matrix set accepted after latency cycles; here a new matrix starts at most every 41 cycles
// RULE14: buffers channelize input and restream results
// RULE15: latency should be at least 30/75/230 cycles
// RULE16: result keeps channel of its source matrix
// ----------------------------------------------------------------------
`ifndef CMI_CONSTS_SVH
`define CMI_CONSTS_SVH
`define CMI_N            4
`define CMI_TRI_CNT      10
`define CMI_CHAN_W       8
`define CMI_CHANNELS     16
`define CMI_LATENCY      30
`define CMI_FIFO_DEPTH   32
`define CMI_PERIOD_W     16
`define CMI_FP_ONE_HALF  32'h3fc00000
`define CMI_FP_HALF      32'h3f000000
`define CMI_RSQRT_SEED   32'h5f3759df
`define CMI_NEWTON_STEPS 3
`endif

// ===== rtl/cmi_pkg.sv
// types shared by the matrix inverter
`include "cmi_consts.svh"
package cmi_pkg;
  // complex single precision element, real part in the upper word
  typedef struct packed {
    logic [31:0] re;
    logic [31:0] im;
  } cmi_cplx_s;
  // one stream beat: channel tag plus element
  typedef struct packed {
    logic [`CMI_CHAN_W-1:0] chan;
    cmi_cplx_s              data;
  } cmi_beat_s;
  // packed lower triangle, column-major
  typedef cmi_cplx_s cmi_tri_t [`CMI_TRI_CNT];
  typedef enum logic [2:0] {
    CMI_IDLE = 3'b000,
    CMI_LOAD = 3'b001,
    CMI_CHOL = 3'b010,
    CMI_TRI  = 3'b011,
    CMI_MULT = 3'b100
  } cmi_state_e;
endpackage

// ===== rtl/cmi_top.sv
// streaming cholesky matrix inverter with its input fifo
`timescale 1ns/1ns
`include "cmi_consts.svh"

// ----------------------------------------------------------------------
// fifo
// ----------------------------------------------------------------------
module cmi_fifo #(
  parameter int W     = 72,
  parameter int DEPTH = 32
) (
  input  wire logic                       clock,     // system clock
  input  wire logic                       nrst,      // async reset, low
  input  wire logic                       in_valid,  // write request
  output logic                            in_ready,  // not full
  input  wire logic [W-1:0]               in_data,   // write word
  output logic                            out_valid, // not empty
  input  wire logic                       out_ready, // read request
  output logic [W-1:0]                    out_data,  // head word
  output logic [$clog2(DEPTH):0]          count      // fill level
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem_ff [DEPTH]; // storage
  logic [AW-1:0] wr_ff;          // write pointer
  logic [AW-1:0] rd_ff;          // read pointer
  logic [AW:0]   cnt_ff;         // words held
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;
  assign in_ready  = cnt_ff != (AW+1)'(DEPTH);
  assign out_valid = cnt_ff != '0;
  assign out_data  = mem_ff[rd_ff];
  assign count     = cnt_ff;
  // data store has no reset, pointers do
  always_ff @(posedge clock) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end
  // pointers and level
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= push ? wr_ff + 1'b1 : wr_ff;
      rd_ff  <= pop ? rd_ff + 1'b1 : rd_ff;
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // cmi_fifo

// ----------------------------------------------------------------------
// inverter top
// ----------------------------------------------------------------------
module cmi_top (
  input  wire logic                   clock,          // 10 MHz system clock
  input  wire logic                   nrst,           // async reset, low
  input  wire logic                   sink_valid,     // input element valid
  input  wire logic [`CMI_CHAN_W-1:0] sink_channel,   // input channel index
  input  wire logic [63:0]            sink_data,      // input element re/im
  output logic                        sink_ready,     // input may be taken
  output logic                        source_valid,   // output element valid
  output logic [`CMI_CHAN_W-1:0]      source_channel, // output channel index
  output logic [63:0]                 source_data     // output element re/im
);
  localparam int N  = `CMI_N;
  localparam int T  = `CMI_TRI_CNT;
  localparam int IW = $clog2(N);
  localparam int EW = $clog2(T);

  // --------------------------------------------------------------------
  // float and complex helpers
  // --------------------------------------------------------------------
  // truncating multiply, denormals flush to zero
  function automatic logic [31:0] fp_mul(input logic [31:0] a, input logic [31:0] b);
    logic [47:0] p;
    logic [9:0]  e;
    p = 48'({1'b1, a[22:0]}) * 48'({1'b1, b[22:0]});
    e = 10'(a[30:23]) + 10'(b[30:23]) - 10'd127 + 10'(p[47]);
    if (!p[47]) p = p << 1;
    if (a[30:23] == 8'h00 || b[30:23] == 8'h00 || e[9] || e == 10'h000) return 32'h0;
    if (e >= 10'h0ff) return {a[31] ^ b[31], 8'hfe, 23'h7fffff};
    return {a[31] ^ b[31], e[7:0], p[46:24]};
  endfunction
  // truncating add
  function automatic logic [31:0] fp_add(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] x, y;
    logic [24:0] mx, my, s;
    logic [7:0]  e, d;
    x = (a[30:0] < b[30:0]) ? b : a;
    y = (a[30:0] < b[30:0]) ? a : b;
    e = x[30:23];
    d = x[30:23] - y[30:23];
    mx = (x[30:23] == 8'h00) ? 25'h0 : {2'b01, x[22:0]};
    my = (y[30:23] == 8'h00 || d > 8'h18) ? 25'h0 : ({2'b01, y[22:0]} >> d);
    s = (x[31] == y[31]) ? mx + my : mx - my;
    if (s == 25'h0) return 32'h0;
    if (s[24]) begin
      s = s >> 1;
      e = e + 8'h01;
    end
    for (int k = 0; k < 24; k++) begin
      if (!s[23] && e > 8'h01) begin
        s = s << 1;
        e = e - 8'h01;
      end
    end
    return {x[31], e, s[22:0]};
  endfunction
  function automatic logic [31:0] fp_neg(input logic [31:0] a);
    return {~a[31], a[30:0]};
  endfunction
  // reciprocal square root by newton steps, so no divider is needed
  function automatic logic [31:0] fp_rsqrt(input logic [31:0] x);
    logic [31:0] y, h;
    y = `CMI_RSQRT_SEED - {1'b0, x[31:1]};
    h = fp_mul(x, `CMI_FP_HALF);
    for (int k = 0; k < `CMI_NEWTON_STEPS; k++) begin
      y = fp_mul(y, fp_add(`CMI_FP_ONE_HALF, fp_neg(fp_mul(h, fp_mul(y, y)))));
    end
    return y;
  endfunction
  function automatic cmi_pkg::cmi_cplx_s c_mul(input cmi_pkg::cmi_cplx_s a,
                                               input cmi_pkg::cmi_cplx_s b);
    return {fp_add(fp_mul(a.re, b.re), fp_neg(fp_mul(a.im, b.im))),
            fp_add(fp_mul(a.re, b.im), fp_mul(a.im, b.re))};
  endfunction
  function automatic cmi_pkg::cmi_cplx_s c_add(input cmi_pkg::cmi_cplx_s a,
                                               input cmi_pkg::cmi_cplx_s b);
    return {fp_add(a.re, b.re), fp_add(a.im, b.im)};
  endfunction
  function automatic cmi_pkg::cmi_cplx_s c_conj(input cmi_pkg::cmi_cplx_s a);
    return {a.re, fp_neg(a.im)};
  endfunction
  function automatic cmi_pkg::cmi_cplx_s c_neg(input cmi_pkg::cmi_cplx_s a);
    return {fp_neg(a.re), fp_neg(a.im)};
  endfunction
  function automatic cmi_pkg::cmi_cplx_s c_scale(input cmi_pkg::cmi_cplx_s a,
                                                 input logic [31:0] r);
    return {fp_mul(a.re, r), fp_mul(a.im, r)};
  endfunction
  // element (i,j) of a packed lower triangle; upper half reads as zero
  function automatic cmi_pkg::cmi_cplx_s pick(input cmi_pkg::cmi_tri_t m,
                                              input int i, input int j);
    if (j > i || i >= N) return '0;
    return m[j * N - (j * (j - 1)) / 2 + (i - j)]; // RULE7
  endfunction

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  cmi_pkg::cmi_state_e          state_ff;   // engine phase
  cmi_pkg::cmi_tri_t            mat_a_ff;   // loaded input triangle
  cmi_pkg::cmi_tri_t            mat_l_ff;   // cholesky factor
  cmi_pkg::cmi_tri_t            mat_j_ff;   // inverse of factor
  cmi_pkg::cmi_tri_t            out_ff;     // result waiting to stream
  logic [31:0]                  recip_ff [N]; // 1/l_kk per column
  logic [IW-1:0]                row_ff;     // walk row
  logic [IW-1:0]                col_ff;     // walk column
  logic [EW-1:0]                elem_ff;    // walk packed index
  logic [`CMI_CHAN_W-1:0]       chan_ff;    // tag of matrix in work, any channel index RULE12
  logic [`CMI_PERIOD_W-1:0]     period_ff;  // cycles until next start
  logic                         send_ff;    // output burst running
  logic [EW-1:0]                send_idx_ff;// output burst index
  logic                         sink_ready_ff;
  logic                         source_valid_ff;
  logic [`CMI_CHAN_W-1:0]       source_channel_ff;
  logic [63:0]                  source_data_ff;
  cmi_pkg::cmi_cplx_s           acc;        // shared dot-product result
  logic                         fifo_ready; // fifo not full
  logic                         fifo_valid; // fifo holds an element
  cmi_pkg::cmi_beat_s           fifo_head;  // fifo head element
  logic [$clog2(`CMI_FIFO_DEPTH):0] fifo_cnt;

  // --------------------------------------------------------------------
  // input buffer: gathers stream elements into whole matrices
  // --------------------------------------------------------------------
  wire fifo_pop = (state_ff == cmi_pkg::CMI_LOAD) && fifo_valid;
  cmi_fifo #(.W($bits(cmi_pkg::cmi_beat_s)), .DEPTH(`CMI_FIFO_DEPTH)) u_in_fifo (
    .clock     (clock),
    .nrst      (nrst),
    .in_valid  (sink_valid && sink_ready_ff),
    .in_ready  (fifo_ready),
    .in_data   ({sink_channel, sink_data}),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_head),
    .count     (fifo_cnt)
  ); // RULE14

  // --------------------------------------------------------------------
  // dot-product engine, N terms wide, shared by all three phases
  // --------------------------------------------------------------------
  always_comb begin
    acc = '0;
    case (state_ff)
      cmi_pkg::CMI_CHOL: begin
        acc = pick(mat_a_ff, int'(row_ff), int'(col_ff));
        for (int k = 0; k < N; k++) begin // RULE3
          if (k < int'(col_ff))
            acc = c_add(acc, c_neg(c_mul(pick(mat_l_ff, int'(row_ff), k),
                                         c_conj(pick(mat_l_ff, int'(col_ff), k)))));
        end
      end
      cmi_pkg::CMI_TRI: begin
        for (int k = 0; k < N; k++) begin
          if (k >= int'(col_ff) && k < int'(row_ff))
            acc = c_add(acc, c_mul(pick(mat_l_ff, int'(row_ff), k),
                                   pick(mat_j_ff, k, int'(col_ff))));
        end
      end
      cmi_pkg::CMI_MULT: begin
        for (int k = 0; k < N; k++) begin // inverse = conj(j)^t * j
          if (k >= int'(row_ff))
            acc = c_add(acc, c_mul(c_conj(pick(mat_j_ff, k, int'(row_ff))),
                                   pick(mat_j_ff, k, int'(col_ff)))); // RULE1
        end
      end
      default: acc = '0;
    endcase
  end

  // per-element results; diagonal ones use the reciprocal, never a divide
  wire                is_diag  = row_ff == col_ff;
  wire [31:0]         diag_rs  = fp_rsqrt(acc.re); // RULE2
  cmi_pkg::cmi_cplx_s chol_val;
  cmi_pkg::cmi_cplx_s tri_val;
  assign chol_val = is_diag ? {fp_mul(acc.re, diag_rs), 32'h0}
                            : c_scale(acc, recip_ff[col_ff]);
  assign tri_val  = is_diag ? {recip_ff[col_ff], 32'h0}
                            : c_neg(c_scale(acc, recip_ff[row_ff])); // RULE2
  wire walk_last  = col_ff == IW'(N - 1);
  wire load_last  = fifo_pop && (elem_ff == EW'(T - 1));
  wire may_start  = period_ff == '0;

  // --------------------------------------------------------------------
  // phase sequencing: load, factor, invert, multiply
  // --------------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_ff <= cmi_pkg::CMI_IDLE;
    end else begin
      case (state_ff)
        cmi_pkg::CMI_IDLE: if (may_start && fifo_valid) state_ff <= cmi_pkg::CMI_LOAD;
        cmi_pkg::CMI_LOAD: if (load_last) state_ff <= cmi_pkg::CMI_CHOL;
        cmi_pkg::CMI_CHOL: if (walk_last) state_ff <= cmi_pkg::CMI_TRI;  // RULE1
        cmi_pkg::CMI_TRI:  if (walk_last) state_ff <= cmi_pkg::CMI_MULT;
        cmi_pkg::CMI_MULT: if (walk_last) state_ff <= cmi_pkg::CMI_IDLE;
        default:           state_ff <= cmi_pkg::CMI_IDLE;
      endcase
    end
  end

  // column-major walk over the lower triangle, restarted each phase
  wire walk_on = (state_ff == cmi_pkg::CMI_CHOL) || (state_ff == cmi_pkg::CMI_TRI) ||
                 (state_ff == cmi_pkg::CMI_MULT);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      row_ff  <= '0;
      col_ff  <= '0;
      elem_ff <= '0;
    end else if (load_last || (walk_on && walk_last)) begin
      row_ff  <= '0;
      col_ff  <= '0;
      elem_ff <= '0;
    end else if (walk_on) begin
      col_ff  <= (row_ff == IW'(N - 1)) ? col_ff + 1'b1 : col_ff; // RULE7
      row_ff  <= (row_ff == IW'(N - 1)) ? col_ff + 1'b1 : row_ff + 1'b1;
      elem_ff <= elem_ff + 1'b1;
    end else if (fifo_pop) begin
      elem_ff <= elem_ff + 1'b1;
    end
  end

  // matrix stores; first element of a matrix fixes its channel tag
  always_ff @(posedge clock) begin
    if (fifo_pop) mat_a_ff[elem_ff] <= fifo_head.data; // RULE4
    if (state_ff == cmi_pkg::CMI_CHOL) mat_l_ff[elem_ff] <= chol_val;
    if (state_ff == cmi_pkg::CMI_CHOL && is_diag) recip_ff[col_ff] <= diag_rs;
    if (state_ff == cmi_pkg::CMI_TRI) mat_j_ff[elem_ff] <= tri_val;
    // safe to overwrite: the prior burst ended long before this phase
    if (state_ff == cmi_pkg::CMI_MULT) out_ff[elem_ff] <= acc; // RULE11
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      chan_ff <= '0;
    end else if (fifo_pop && elem_ff == '0) begin
      chan_ff <= fifo_head.chan; // RULE16
    end
  end

  // start spacing: a new matrix is taken no sooner than latency cycles apart
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      period_ff <= '0;
    end else if (state_ff == cmi_pkg::CMI_IDLE && may_start && fifo_valid) begin
      period_ff <= `CMI_PERIOD_W'(`CMI_LATENCY - 1); // RULE13
    end else if (!may_start) begin
      period_ff <= period_ff - 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // output buffer: restreams the result as one unbroken burst
  // --------------------------------------------------------------------
  wire mult_done = (state_ff == cmi_pkg::CMI_MULT) && walk_last;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      send_ff           <= 1'b0;
      send_idx_ff       <= '0;
      source_valid_ff   <= 1'b0;
      source_channel_ff <= '0;
      source_data_ff    <= '0;
    end else begin
      if (mult_done) begin
        send_ff     <= 1'b1;
        send_idx_ff <= '0;
      end else if (send_ff) begin
        send_ff     <= send_idx_ff != EW'(T - 1); // RULE9
        send_idx_ff <= send_idx_ff + 1'b1;
      end
      source_valid_ff   <= send_ff;
      // tag latched at the end of the multiply, since the next load may retag chan_ff mid-burst
      source_channel_ff <= mult_done ? chan_ff : source_channel_ff; // RULE10 RULE16
      source_data_ff    <= send_ff ? out_ff[send_idx_ff] : source_data_ff;
    end
  end

  // registered ready cuts off above 30 words; its one-cycle lag lets the fifo fill to all 32, so it never overflows
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sink_ready_ff <= 1'b0;
    end else begin
      sink_ready_ff <= fifo_ready && (fifo_cnt <= ($clog2(`CMI_FIFO_DEPTH)+1)'(`CMI_FIFO_DEPTH - 2));
    end
  end

  assign sink_ready     = sink_ready_ff;
  assign source_valid   = source_valid_ff;
  assign source_channel = source_channel_ff;
  assign source_data    = source_data_ff;
endmodule // cmi_top

// ===== bench/cmi_top_assertions.sv
// port-level assertion checker for the streaming matrix inverter
`timescale 1ns/1ns
`include "cmi_consts.svh"
module cmi_checker (
  input wire logic                   clock,          // system clock
  input wire logic                   nrst,           // async reset, low
  input wire logic                   sink_valid,     // input element valid
  input wire logic [`CMI_CHAN_W-1:0] sink_channel,   // input channel index
  input wire logic [63:0]            sink_data,      // input element
  input wire logic                   sink_ready,     // input may be taken
  input wire logic                   source_valid,   // output element valid
  input wire logic [`CMI_CHAN_W-1:0] source_channel, // output channel index
  input wire logic [63:0]            source_data     // output element
);
  // ----------------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------------
  logic [15:0]  in_cnt_ff;  // beats taken since reset
  logic [15:0]  out_cnt_ff; // result beats seen since reset
  logic [7:0]   gap_ff;     // idle cycles since last result beat, saturating
  logic [255:0] seen_ff;    // channels that opened a matrix
  wire logic         take      = sink_valid && sink_ready;           // beat accepted
  wire logic         open_mat  = take && (in_cnt_ff % 16'd10 == 16'd0); // first beat
  wire logic [255:0] nxt_seen  = seen_ff | ({255'h0, open_mat} << sink_channel);
  wire logic [7:0]   nxt_gap   = source_valid ? 8'h00 : (gap_ff == 8'hff ? gap_ff : gap_ff + 8'h01);
  // gap counter starts saturated so the first burst needs no gap
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      in_cnt_ff  <= 16'h0000;
      out_cnt_ff <= 16'h0000;
      gap_ff     <= 8'hff;
      seen_ff    <= '0;
    end else begin
      in_cnt_ff  <= in_cnt_ff + {15'h0000, take};
      out_cnt_ff <= out_cnt_ff + {15'h0000, source_valid};
      gap_ff     <= nxt_gap;
      seen_ff    <= nxt_seen;
    end
  end
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_burst_ten_long: assert property ($rose(source_valid) |-> source_valid[*8] ##1 source_valid[*2] ##1 !source_valid)
    else $error("result burst is not ten cycles");
  a_chan_held_burst: assert property (source_valid && $past(source_valid) |-> $stable(source_channel))
    else $error("channel changed inside a burst");
  a_burst_gap_min: assert property ($rose(source_valid) |-> gap_ff >= 8'd30)
    else $error("bursts closer than the latency");
  a_out_after_in: assert property (source_valid |-> in_cnt_ff >= out_cnt_ff - (out_cnt_ff % 16'd10) + 16'd10)
    else $error("result before its whole matrix was taken");
  a_chan_from_src: assert property (source_valid |-> seen_ff[source_channel])
    else $error("result channel never opened a matrix");
  a_ready_after_rst: assert property ($rose(nrst) |=> sink_ready)
    else $error("input not ready after reset");
  a_refuse_when_full: assert property ($fell(sink_ready) |-> (in_cnt_ff - out_cnt_ff) >= 16'd30)
    else $error("input refused with room in the buffer");
  a_data_hold_idle: assert property (!source_valid && !$past(source_valid) |-> $stable(source_data))
    else $error("output data moved outside a burst");
  c_burst_seen: cover property ($rose(source_valid));
  c_fifo_full: cover property ($fell(sink_ready));
  c_top_chan: cover property (source_valid && source_channel == 8'hff);
endmodule // cmi_checker

// ===== bench/cmi_partner.sv
// upstream source and downstream collector facing the matrix inverter
`timescale 1ns/1ns
`include "cmi_consts.svh"
module cmi_partner (
  input wire logic                   clock,          // system clock
  input wire logic                   nrst,           // async reset, low
  input wire logic                   sink_ready,     // inverter takes beats
  input wire logic                   source_valid,   // result valid
  input wire logic [`CMI_CHAN_W-1:0] source_channel, // result channel
  input wire logic [63:0]            source_data,    // result element
  output logic                       sink_valid,     // beat valid
  output logic [`CMI_CHAN_W-1:0]     sink_channel,   // beat channel
  output logic [63:0]                sink_data       // beat element
);
  cmi_pkg::cmi_beat_s got_q [$]; // result beats in arrival order
  // quiet source at time zero
  initial begin
    sink_valid   = 1'b0;
    sink_channel = 8'h00;
    sink_data    = 64'h0;
  end
  // present a beat and hold it until an edge samples ready high
  task automatic send_beat(input cmi_pkg::cmi_beat_s b);
    sink_valid   <= 1'b1;
    sink_channel <= b.chan;
    sink_data    <= b.data;
    do @(posedge clock); while (sink_ready !== 1'b1);
  endtask
  // released data shows the inverse so stale words never look valid
  task automatic idle(input int n);
    sink_valid <= 1'b0;
    sink_data  <= ~sink_data;
    repeat (n) @(posedge clock);
  endtask
  // one whole lower triangle, then the inter-matrix pause
  task automatic send_matrix(input cmi_pkg::cmi_beat_s m [10], input int gap);
    for (int k = 0; k < 10; k++) send_beat(m[k]);
    if (gap > 0) idle(gap);
  endtask
  // no backpressure downstream, so every valid cycle is one beat
  always @(posedge clock) begin
    if (source_valid === 1'b1) got_q.push_back({source_channel, source_data});
  end
endmodule // cmi_partner

// ===== bench/test_cholesky_matrix_inverter.sv
// self-checking bench for the streaming matrix inverter
`timescale 1ns/1ns
`include "cmi_consts.svh"
module test_cholesky_matrix_inverter;
  // two identical hermitian 2x2 blocks: diagonal a, lower off-diagonal b + jc
  typedef struct { logic [7:0] chan; shortreal a, b, c; } cmi_row_s;
  logic                   clock = 1'b0;    // 10 MHz clock
  logic                   nrst  = 1'b0;    // async reset, low
  wire logic              sink_valid;      // beat valid
  wire logic              sink_ready;      // beat taken
  wire logic              source_valid;    // result valid
  wire logic [7:0]        sink_channel;    // beat channel
  wire logic [7:0]        source_channel;  // result channel
  wire logic [63:0]       sink_data;       // beat element
  wire logic [63:0]       source_data;     // result element
  int                     n_errors = 0;    // mismatches
  int                     samples_checked = 0; // comparisons
  bit                     saw_full = 1'b0; // buffer refused once
  cmi_row_s rows [4] = '{'{8'h05, 4.0, 0.0, 0.0}, '{8'h0f, 2.0, 1.0, 0.0},
                         '{8'ha3, 2.0, 0.0, 1.0}, '{8'hff, 3.0, 1.0, -1.0}};
  always #50 clock = ~clock;
  cmi_top dut (.clock(clock), .nrst(nrst), .sink_valid(sink_valid), .sink_channel(sink_channel),
    .sink_data(sink_data), .sink_ready(sink_ready), .source_valid(source_valid),
    .source_channel(source_channel), .source_data(source_data));
  cmi_partner u_far (.clock(clock), .nrst(nrst), .sink_ready(sink_ready),
    .source_valid(source_valid), .source_channel(source_channel), .source_data(source_data),
    .sink_valid(sink_valid), .sink_channel(sink_channel), .sink_data(sink_data));
  // note a refused beat while the source waits
  always @(posedge clock) begin
    if (nrst && sink_valid && sink_ready === 1'b0) saw_full <= 1'b1;
  end
  task automatic fail(input string msg);
    n_errors++;
    $display("ERROR %0t %s", $time, msg);
  endtask
  // element k of a column-major lower triangle for the block layout
  function automatic cmi_pkg::cmi_cplx_s elem(int k, shortreal d, shortreal re, shortreal im);
    cmi_pkg::cmi_cplx_s e;
    e = '0;
    if (k == 0 || k == 4 || k == 7 || k == 9) e.re = $shortrealtobits(d);
    else if (k == 1 || k == 8) begin
      e.re = $shortrealtobits(re);
      e.im = $shortrealtobits(im);
    end
    return e;
  endfunction
  // approximate arithmetic, so compare with a relative tolerance
  function automatic bit near(logic [31:0] g, logic [31:0] e);
    shortreal gv, ev;
    if ($isunknown(g)) return 1'b0;
    gv = $bitstoshortreal(g);
    ev = $bitstoshortreal(e);
    return (gv - ev) * (gv - ev) <= (1e-3 * ev) * (1e-3 * ev) + 1e-8;
  endfunction
  task automatic send_row(input cmi_row_s r, input int gap);
    cmi_pkg::cmi_beat_s m [10];
    for (int k = 0; k < 10; k++) m[k] = '{chan: r.chan, data: elem(k, r.a, r.b, r.c)};
    u_far.send_matrix(m, gap);
  endtask
  task automatic wait_out(input int n);
    for (int i = 0; i < 3000 && u_far.got_q.size() < n; i++) @(posedge clock);
    if (u_far.got_q.size() < n) fail("results missing");
  endtask
  // inverse of the block: a/det on the diagonal, -(b+jc)/det below it
  task automatic check_out(input cmi_row_s r);
    cmi_pkg::cmi_beat_s g;
    cmi_pkg::cmi_cplx_s e;
    shortreal           det;
    det = r.a * r.a - r.b * r.b - r.c * r.c;
    for (int k = 0; k < 10 && u_far.got_q.size() > 0; k++) begin
      g = u_far.got_q.pop_front();
      e = elem(k, r.a / det, -r.b / det, -r.c / det);
      samples_checked++;
      if (g.chan !== r.chan) fail("wrong channel tag");
      if (!near(g.data.re, e.re) || !near(g.data.im, e.im)) fail("wrong element");
    end
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    samples_checked++;
    if (sink_ready !== 1'b1) fail("not ready after reset");
    foreach (rows[i]) send_row(rows[i], `CMI_LATENCY - 10);
    wait_out(40);
    foreach (rows[i]) check_out(rows[i]);
    // back-to-back matrices overrun the engine and must fill the buffer
    for (int i = 0; i < 6; i++) send_row(rows[i % 4], 0);
    u_far.idle(1);
    samples_checked++;
    if (!saw_full) fail("buffer never refused");
    wait_out(60);
    for (int i = 0; i < 6; i++) check_out(rows[i % 4]);
    // reset in the middle of a result burst
    send_row(rows[3], 20);
    for (int i = 0; i < 500 && source_valid !== 1'b1; i++) @(posedge clock);
    @(posedge clock);
    nrst <= 1'b0;
    @(negedge clock);
    samples_checked++;
    if (source_valid !== 1'b0 || sink_ready !== 1'b0) fail("outputs live in reset");
    @(posedge clock);
    nrst <= 1'b1;
    u_far.got_q.delete();
    repeat (2) @(posedge clock);
    samples_checked++;
    if (sink_ready !== 1'b1) fail("not ready after second reset");
    repeat (150) @(posedge clock);
    samples_checked++;
    if (u_far.got_q.size() != 0) fail("stale result after reset");
    conclude();
  end
  // watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clock);
    fail("watchdog expired");
    conclude();
  end
endmodule // test_cholesky_matrix_inverter
bind cmi_top cmi_checker u_chk (.clock(clock), .nrst(nrst), .sink_valid(sink_valid),
  .sink_channel(sink_channel), .sink_data(sink_data), .sink_ready(sink_ready),
  .source_valid(source_valid), .source_channel(source_channel), .source_data(source_data));
